// file: src/hfc_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: AXI4-Lite byte addressing, 32-bit words.
// Notes:   Included by the design modules hfc_clk_div and hfc_osc_ctrl; the package does not include it.
`ifndef HFC_MAP_SVH
`define HFC_MAP_SVH
`define HFC_IDX_OSC_CTRL      8'hb2
`define HFC_IDX_OSC_TRIM      8'hb3
`define HFC_IDX_CLK_SEL       8'hc0
`define HFC_IDX_LF_CTRL       8'hc1
`define HFC_IDX_IRQ_STAT      8'hc2
`define HFC_IDX_IRQ_MASK      8'hc3
`define HFC_IDX_BUS_PWR       8'hc4
`define HFC_OSC_CTRL_RESET    8'h80
`define HFC_TRIM_RESET        5'h10
`define HFC_BIT_ENABLE        7
`define HFC_BIT_READY         6
`define HFC_BIT_SUSPEND       5
`define HFC_SETTLE_NS         1000
`define HFC_CLK_PERIOD_NS     8
`define HFC_SETTLE_CYC        ((`HFC_SETTLE_NS + `HFC_CLK_PERIOD_NS - 1) / `HFC_CLK_PERIOD_NS)
`define HFC_OSC_BASE_HALF     4
`endif

// file: src/hfc_pkg.sv
// Purpose: Types shared by the oscillator control block.
// Assumes: Constants live in hfc_map.svh.
// Notes:   None.
package hfc_pkg;
  typedef enum logic [1:0] {
    HFC_OFF     = 2'b00,
    HFC_SETTLE  = 2'b01,
    HFC_RUN     = 2'b10,
    HFC_SUSPEND = 2'b11
  } hfc_state_e;
  typedef enum logic [1:0] {
    HFC_SRC_HF   = 2'b00,
    HFC_SRC_EXT  = 2'b01,
    HFC_SRC_MULT = 2'b10,
    HFC_SRC_LF   = 2'b11
  } hfc_src_e;
  typedef struct packed {
    logic       hf_osc_enable;
    logic       suspend;
    logic [1:0] system_clock_divide_select;
  } hfc_ctrl_s;
  typedef struct packed {
    hfc_src_e   sys_src;
    logic [1:0] usb_src;
  } hfc_sel_s;
endpackage

// file: src/hfc_clk_div.sv
// Purpose: Enable-pulse divider modelling an oscillator and its post-divider.
// Assumes: One clock; outputs are one-cycle enables.
// Notes:   Period grows with trim, so code zero is fastest.
`timescale 1ns/1ps
`include "hfc_map.svh"
module hfc_clk_div
  import hfc_pkg::*;
(
  input  wire logic       ref_clk,   // System clock.
  input  wire logic       rst_n,     // Synchronised reset, active low.
  input  wire logic       run,       // Oscillator running.
  input  wire logic [4:0] trim,      // Period trim, 0 fastest.
  input  wire logic [1:0] div_sel,   // Post-divide select.
  output logic            osc_tick,  // Oscillator edge enable.
  output logic            out_tick   // Divided clock enable.
);
  logic [6:0] cnt_q;
  logic [2:0] post_q;
  logic [6:0] limit;
  logic [2:0] post_lim;

  assign limit = 7'(`HFC_OSC_BASE_HALF) + {2'b00, trim};

  always_comb begin
    case (div_sel)
      2'b00:   post_lim = 3'h7;
      2'b01:   post_lim = 3'h3;
      2'b10:   post_lim = 3'h1;
      default: post_lim = 3'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 7'h00;
      osc_tick <= 1'b0;
    end else if (!run) begin
      cnt_q    <= 7'h00;
      osc_tick <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q    <= 7'h00;
      osc_tick <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 7'h01;
      osc_tick <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      post_q   <= 3'h0;
      out_tick <= 1'b0;
    end else if (!run) begin
      post_q   <= 3'h0;
      out_tick <= 1'b0;
    end else if (osc_tick) begin
      out_tick <= (post_q >= post_lim);
      post_q   <= (post_q >= post_lim) ? 3'h0 : post_q + 3'h1;
    end else begin
      out_tick <= 1'b0;
    end
  end
endmodule // hfc_clk_div

// file: src/hfc_osc_ctrl.sv
// Purpose: High-frequency oscillator control, system clock derivation, suspend and wake.
// Assumes: AXI4-Lite slave; wake inputs are asynchronous pins.
// Notes:   Clocks are represented as one-cycle enables on ref_clk.
// Contract
// - After reset the system clock source is the internal high-frequency oscillator.
// - Divide select 00/01/10/11 gives the oscillator divided by 8/4/2/1.
// - After reset the divide ratio is 8.
// - Software enables, disables and adjusts both internal oscillators through bits.
// - The trim value sets the oscillator period and resets to the calibrated value.
// - Writing one to the suspend bit stops the oscillator.
// - A suspended oscillator restarts on a non-idle USB event.
// - A suspended oscillator restarts when bus power matches the chosen polarity.
// - USB wake detection works while the transceiver is disabled.
// - System clock source is HF, LF, external, or the 4x multiplier halved.
// - USB clock source is HF, external, or the undivided 4x multiplier.
// - Trim is the low five bits, zero fastest and all ones slowest.
`timescale 1ns/1ps
`include "hfc_map.svh"
module hfc_osc_ctrl
  import hfc_pkg::*;
(
  input  wire logic        ref_clk,          // Clock, 125 MHz.
  input  wire logic        rst_n,            // Asynchronous reset, active low.
  input  wire logic [11:0] s_axi_awaddr,     // Write address.
  input  wire logic        s_axi_awvalid,    // Write address valid.
  output logic             s_axi_awready,    // Write address ready.
  input  wire logic [31:0] s_axi_wdata,      // Write data.
  input  wire logic [3:0]  s_axi_wstrb,      // Write strobes.
  input  wire logic        s_axi_wvalid,     // Write data valid.
  output logic             s_axi_wready,     // Write data ready.
  output logic [1:0]       s_axi_bresp,      // Write response.
  output logic             s_axi_bvalid,     // Write response valid.
  input  wire logic        s_axi_bready,     // Write response ready.
  input  wire logic [11:0] s_axi_araddr,     // Read address.
  input  wire logic        s_axi_arvalid,    // Read address valid.
  output logic             s_axi_arready,    // Read address ready.
  output logic [31:0]      s_axi_rdata,      // Read data.
  output logic [1:0]       s_axi_rresp,      // Read response.
  output logic             s_axi_rvalid,     // Read data valid.
  input  wire logic        s_axi_rready,     // Read data ready.
  input  wire logic        usb_resume,       // Non-idle USB line activity pin.
  input  wire logic        bus_power,        // Bus-power sense pin.
  input  wire logic        ext_osc_tick,     // External oscillator enable.
  input  wire logic        mult_tick,        // 4x multiplier enable.
  input  wire logic        lf_osc_tick,      // Low-frequency oscillator enable.
  output logic             hf_osc_run,       // HF oscillator running.
  output logic             system_clock,     // System clock enable.
  output logic             usb_side_clock,   // USB clock enable.
  output logic             lf_osc_enable,    // LF oscillator enable.
  output logic [3:0]       lf_osc_adjust,    // LF oscillator adjust.
  output logic             irq               // Interrupt, active high.
);
  logic        rst_s1_q, rst_sync_n;
  logic [1:0]  usb_sync_q, vbus_sync_q;
  hfc_state_e  state_q;
  hfc_ctrl_s   ctrl_q;
  hfc_sel_s    sel_q;
  logic [4:0]  hf_osc_period_trim;
  logic [4:0]  lf_ctrl_q;
  logic        bus_power_polarity_select;
  logic [1:0]  irq_stat_q, irq_mask_q, ev;
  logic [15:0] settle_q;
  logic        hf_osc_ready_flag;
  logic        hf_tick, hf_div_tick;
  logic        aw_hold_q, w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go, wr_hit, rd_go;
  logic [9:0]  wr_idx, rd_idx;
  logic        wake;
  logic        ready_rise;
  logic [1:0]  mult_half_q;

  // Reset is asserted at once and released through two flops, so every register
  // below leaves reset on the same clock edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // Wake pins are synchronised on the always-running reference clock, so detection
  // does not depend on the transceiver or the stopped oscillator.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      usb_sync_q  <= 2'b00;
      vbus_sync_q <= 2'b00;
    end else begin
      usb_sync_q  <= {usb_sync_q[0], usb_resume};
      vbus_sync_q <= {vbus_sync_q[0], bus_power};
    end
  end

  // Wake is line activity, or bus power standing at the selected polarity.
  assign wake = usb_sync_q[1]
              | (vbus_sync_q[1] == bus_power_polarity_select);

  // AXI write: address and data taken in either order, response after both.
  // Only byte lane 0 carries register bits; a write without it is only acknowledged.
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_go  = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_idx = awaddr_q[11:2];
  assign rd_idx = s_axi_araddr[11:2];

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // A write to an unmapped index is answered with a slave error and changes nothing.
  always_comb begin
    case (wr_idx)
      10'(`HFC_IDX_OSC_CTRL), 10'(`HFC_IDX_OSC_TRIM), 10'(`HFC_IDX_CLK_SEL),
      10'(`HFC_IDX_LF_CTRL), 10'(`HFC_IDX_IRQ_STAT), 10'(`HFC_IDX_IRQ_MASK),
      10'(`HFC_IDX_BUS_PWR): wr_hit = 1'b1;
      default:               wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; suspend is a write-one trigger cleared by wake.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= '{hf_osc_enable:        1'(`HFC_OSC_CTRL_RESET >> `HFC_BIT_ENABLE),
                  suspend:              1'b0,
                  system_clock_divide_select: 2'(`HFC_OSC_CTRL_RESET)};
    end else begin
      if (wr_go && wr_idx == 10'(`HFC_IDX_OSC_CTRL) && wstrb_q[0]) begin
        ctrl_q.hf_osc_enable        <= wdata_q[`HFC_BIT_ENABLE];
        ctrl_q.system_clock_divide_select <= wdata_q[1:0];
        if (wdata_q[`HFC_BIT_SUSPEND]) begin
          ctrl_q.suspend <= 1'b1;
        end
      end
      if (state_q == HFC_SUSPEND && wake) begin
        ctrl_q.suspend <= 1'b0;
      end
    end
  end

  // Trim, selectors, polarity and mask are plain read/write registers.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hf_osc_period_trim        <= `HFC_TRIM_RESET;
      sel_q                     <= '{sys_src: HFC_SRC_HF, usb_src: 2'b00};
      lf_ctrl_q                 <= 5'h00;
      bus_power_polarity_select <= 1'b1;
      irq_mask_q                <= 2'b00;
    end else if (wr_go && wstrb_q[0]) begin
      case (wr_idx)
        10'(`HFC_IDX_OSC_TRIM): hf_osc_period_trim <= wdata_q[4:0];
        10'(`HFC_IDX_CLK_SEL):  sel_q <= hfc_sel_s'(wdata_q[3:0]);
        10'(`HFC_IDX_LF_CTRL):  lf_ctrl_q <= wdata_q[4:0];
        10'(`HFC_IDX_BUS_PWR):  bus_power_polarity_select <= wdata_q[0];
        10'(`HFC_IDX_IRQ_MASK): irq_mask_q <= wdata_q[1:0];
        default:                ;
      endcase
    end
  end

  // Oscillator state: settle counter guards the ready flag.
  // Reset enters settling, so the oscillator runs and ready stays low at first.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q  <= HFC_SETTLE;
      settle_q <= 16'h0000;
    end else begin
      case (state_q)
        HFC_OFF: begin
          settle_q <= 16'h0000;
          if (ctrl_q.hf_osc_enable) begin
            state_q <= HFC_SETTLE;
          end
        end
        HFC_SETTLE: begin
          if (!ctrl_q.hf_osc_enable) begin
            state_q <= HFC_OFF;
          end else if (ctrl_q.suspend) begin
            state_q <= HFC_SUSPEND;
          end else if (settle_q >= 16'(`HFC_SETTLE_CYC - 1)) begin
            state_q <= HFC_RUN;
          end else begin
            settle_q <= settle_q + 16'h0001;
          end
        end
        HFC_RUN: begin
          if (!ctrl_q.hf_osc_enable) begin
            state_q <= HFC_OFF;
          end else if (ctrl_q.suspend) begin
            state_q <= HFC_SUSPEND;
          end
        end
        HFC_SUSPEND: begin
          settle_q <= 16'h0000;
          if (wake) begin
            state_q <= HFC_SETTLE;
          end
        end
        default: state_q <= HFC_OFF;
      endcase
    end
  end

  assign hf_osc_ready_flag = (state_q == HFC_RUN);
  assign hf_osc_run = (state_q == HFC_RUN) || (state_q == HFC_SETTLE);

  hfc_clk_div u_hf_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_sync_n),
    .run      (hf_osc_run),
    .trim     (hf_osc_period_trim),
    .div_sel  (ctrl_q.system_clock_divide_select),
    .osc_tick (hf_tick),
    .out_tick (hf_div_tick)
  );

  // The multiplier output is halved for the system clock: every second
  // multiplier tick gives one pulse.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mult_half_q <= 2'b00;
    end else if (mult_tick) begin
      mult_half_q <= {~mult_half_q[0], ~mult_half_q[0]};
    end else begin
      mult_half_q[1] <= 1'b0;
    end
  end

  // Both clock outputs are registered one-cycle enables; switching a selector can still
  // put an old-source pulse and a new-source pulse in adjacent cycles.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      system_clock   <= 1'b0;
      usb_side_clock <= 1'b0;
    end else begin
      case (sel_q.sys_src)
        HFC_SRC_HF:   system_clock <= hf_div_tick;
        HFC_SRC_EXT:  system_clock <= ext_osc_tick;
        HFC_SRC_MULT: system_clock <= mult_half_q[1];
        HFC_SRC_LF:   system_clock <= lf_osc_tick;
        default:      system_clock <= hf_div_tick;
      endcase
      case (sel_q.usb_src)
        2'b00:   usb_side_clock <= hf_tick;
        2'b01:   usb_side_clock <= ext_osc_tick;
        2'b10:   usb_side_clock <= mult_tick;
        default: usb_side_clock <= hf_tick;
      endcase
    end
  end

  assign lf_osc_enable = lf_ctrl_q[4];
  assign lf_osc_adjust = lf_ctrl_q[3:0];

  // Sticky events: bit0 wake from suspend, bit1 ready rise. Set wins over clear.
  // The ready event marks only the edge that moves settling into running, so a
  // write-one clear is not undone while the oscillator keeps running.
  assign ready_rise = (state_q == HFC_SETTLE) && ctrl_q.hf_osc_enable && !ctrl_q.suspend
                    && (settle_q >= 16'(`HFC_SETTLE_CYC - 1));
  assign ev = {ready_rise, state_q == HFC_SUSPEND && wake};

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat_q <= 2'b00;
    end else if (wr_go && wr_idx == 10'(`HFC_IDX_IRQ_STAT) && wstrb_q[0]) begin
      irq_stat_q <= (irq_stat_q & ~wdata_q[1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  // Level interrupt: high while any unmasked status bit is set.
  assign irq = |(irq_stat_q & irq_mask_q);

  // AXI read: one cycle from address to data.
  // Unmapped indices answer with a slave error and zero data.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (rd_idx)
        10'(`HFC_IDX_OSC_CTRL): s_axi_rdata <= {24'h0, ctrl_q.hf_osc_enable,
                                   hf_osc_ready_flag, 4'h0, ctrl_q.system_clock_divide_select};
        10'(`HFC_IDX_OSC_TRIM): s_axi_rdata <= {27'h0, hf_osc_period_trim};
        10'(`HFC_IDX_CLK_SEL):  s_axi_rdata <= {28'h0, sel_q};
        10'(`HFC_IDX_LF_CTRL):  s_axi_rdata <= {27'h0, lf_ctrl_q};
        10'(`HFC_IDX_IRQ_STAT): s_axi_rdata <= {30'h0, irq_stat_q};
        10'(`HFC_IDX_IRQ_MASK): s_axi_rdata <= {30'h0, irq_mask_q};
        10'(`HFC_IDX_BUS_PWR):  s_axi_rdata <= {30'h0, vbus_sync_q[1],
                                   bus_power_polarity_select};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // hfc_osc_ctrl

// file: verif/hfc_wake_model.sv
// Purpose: Far-side model: USB line activity, bus-power pin and source ticks.
// Assumes: Same clock domain as the block.
// Notes:   Activity and power follow the bench requests one cycle later.
`timescale 1ns/1ps
module hfc_wake_model (
  input  wire logic ref_clk,             // Clock.
  input  wire logic usb_req,             // Bench asks for line activity.
  input  wire logic pwr_req,             // Bench asks for bus power.
  output logic      usb_resume   = 1'b0, // Line activity.
  output logic      bus_power    = 1'b0, // Bus-power sense.
  output logic      ext_osc_tick = 1'b0, // External source tick.
  output logic      mult_tick    = 1'b0, // Multiplier tick.
  output logic      lf_osc_tick  = 1'b0  // LF source tick.
);
  logic [3:0] cnt_q = 4'h0;
  always_ff @(posedge ref_clk) begin
    cnt_q        <= cnt_q + 4'h1;
    usb_resume   <= usb_req;
    bus_power    <= pwr_req;
    ext_osc_tick <= (cnt_q == 4'h3);
    mult_tick    <= (cnt_q == 4'h7);
    lf_osc_tick  <= (cnt_q == 4'hf);
  end
endmodule // hfc_wake_model

// file: verif/hfc_osc_ctrl_assertions.sv
// Purpose: Port checks for the oscillator control block.
// Assumes: One clock, rst_n active low.
// Notes:   Bound into hfc_osc_ctrl.
`timescale 1ns/1ps
module hfc_osc_ctrl_assertions (
  input wire logic        ref_clk,       // Clock.
  input wire logic        rst_n,         // Reset.
  input wire logic        s_axi_awready, // Write address ready.
  input wire logic        s_axi_wready,  // Write data ready.
  input wire logic [1:0]  s_axi_bresp,   // Write response.
  input wire logic        s_axi_bvalid,  // Write response valid.
  input wire logic        s_axi_bready,  // Write response ready.
  input wire logic [11:0] s_axi_araddr,  // Read address.
  input wire logic        s_axi_arvalid, // Read address valid.
  input wire logic        s_axi_arready, // Read address ready.
  input wire logic [31:0] s_axi_rdata,   // Read data.
  input wire logic [1:0]  s_axi_rresp,   // Read response.
  input wire logic        s_axi_rvalid,  // Read valid.
  input wire logic        s_axi_rready,  // Read ready.
  input wire logic        hf_osc_run,    // Oscillator running.
  input wire logic        system_clock   // System clock enable.
);
  logic [11:0] ar_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ar_q <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  sequence ar_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ctrl_ans_s;
    s_axi_rvalid && ar_q == 12'h2c8;
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_answer_a: assert property (ar_taken_s |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read data not zero");
  ctrl_zero_a: assert property (ctrl_ans_s |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5:2] == 4'h0)
    else $error("control unused bits set");
  ready_run_a: assert property (ctrl_ans_s and s_axi_rdata[6] |-> hf_osc_run)
    else $error("ready while stopped");
  run_up_a: assert property ($rose(rst_n) |-> ##[1:4] hf_osc_run)
    else $error("oscillator not started after reset");
  system_clock_pulse_a: assert property (system_clock |=> !system_clock)
    else $error("system clock enable too wide");
endmodule // hfc_osc_ctrl_assertions
bind hfc_osc_ctrl hfc_osc_ctrl_assertions u_chk (.ref_clk, .rst_n, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hf_osc_run, .system_clock);

// file: verif/hf_oscillator_system_clock_control_test.sv
// Purpose: Register-level test of the oscillator control block.
// Assumes: 125 MHz clock, AXI4-Lite master tasks.
// Notes:   Trim zero gives 5 cycles per oscillator tick.
`timescale 1ns/1ps
module hf_oscillator_system_clock_control_test;
  logic ref_clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, usb_req = 1'b0, pwr_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, run, sclk, uclk, lf_en, irq;
  logic usb_resume, bus_power, ext_t, mult_t, lf_t;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [3:0] lf_adj;
  int n_errors = 0, cmp_count = 0, cyc = 0, p, i;
  always #4 ref_clk = ~ref_clk;
  hfc_osc_ctrl u_hfc_osc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .usb_resume(usb_resume), .bus_power(bus_power), .ext_osc_tick(ext_t), .mult_tick(mult_t),
    .lf_osc_tick(lf_t), .hf_osc_run(run), .system_clock(sclk), .usb_side_clock(uclk),
    .lf_osc_enable(lf_en), .lf_osc_adjust(lf_adj), .irq(irq));
  hfc_wake_model u_hfc_wake_model (.ref_clk(ref_clk), .usb_req(usb_req), .pwr_req(pwr_req),
    .usb_resume(usb_resume), .bus_power(bus_power), .ext_osc_tick(ext_t),
    .mult_tick(mult_t), .lf_osc_tick(lf_t));
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Address and data stay up until each is taken; bready holds until bvalid.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!tb) begin
      @(negedge ref_clk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, tb;
    tb = 1'b0;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!tb) begin
      @(negedge ref_clk);
      ta = arvalid && arready; tb = rvalid; d = rdata; r = rresp;
      @(posedge ref_clk);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end
  endtask
  // Cycles between two enable pulses; the first two gaps after a change are skipped.
  task automatic per(input bit u);
    repeat (2) begin
      do @(negedge ref_clk); while (!(u ? uclk : sclk));
      p = 0;
      do begin @(negedge ref_clk); p++; end while (!(u ? uclk : sclk));
    end
  endtask
  task automatic wait_run(input logic v);
    for (int k = 0; k < 60 && run !== v; k++) @(negedge ref_clk);
    chk(32'(run), 32'(v));
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(12'h2c8); chk(d, 32'h80);
    rd(12'h2cc); chk(d, 32'h10);
    rd(12'h310); chk(d, 32'h1);
    repeat (150) @(posedge ref_clk);
    rd(12'h2c8); chk(d, 32'hc0);
    wr(12'h2cc, 32'hff); rd(12'h2cc); chk(d, 32'h1f);
    wr(12'h2cc, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(12'h2c8, 32'h80 | i); per(1'b0); chk(32'(p), 32'(5 * (8 >> i)));
    end
    wr(12'h2cc, 32'h1f); per(1'b0); chk(32'(p), 32'd36);
    $display("test reset, trim and divide done");
    wr(12'h30c, 32'h1); wr(12'h308, 32'h3); @(negedge ref_clk); chk(32'(irq), 32'h0);
    wr(12'h2c8, 32'ha3); wait_run(1'b0);
    rd(12'h2c8); chk(d, 32'h83);
    usb_req <= 1'b1; wait_run(1'b1);
    usb_req <= 1'b0;
    repeat (150) @(posedge ref_clk);
    chk(32'(irq), 32'h1); rd(12'h308); chk(d, 32'h3);
    wr(12'h308, 32'h1); @(negedge ref_clk); chk(32'(irq), 32'h0);
    wr(12'h308, 32'h2);
    wr(12'h2c8, 32'ha3); wait_run(1'b0);
    pwr_req <= 1'b1; wait_run(1'b1);
    pwr_req <= 1'b0;
    $display("test suspend and wake done");
    wr(12'h2c8, 32'h0); wait_run(1'b0); rd(12'h2c8); chk(d, 32'h0);
    wr(12'h2c8, 32'h80); wait_run(1'b1);
    wr(12'h304, 32'h1a); chk({lf_en, lf_adj}, 32'h1a);
    wr(12'h300, 32'h0a); rd(12'h300); chk(d, 32'h0a);
    per(1'b0); chk(32'(p), 32'd32);
    per(1'b1); chk(32'(p), 32'd16);
    wr(12'h300, 32'h0d); per(1'b0); chk(32'(p), 32'd16);
    per(1'b1); chk(32'(p), 32'd16);
    rd(12'h000); chk(d, 32'h0); chk(32'(r), 32'h2);
    wr(12'h000, 32'h1); chk(32'(r), 32'h2);
    $display("test selectors and errors done");
    close_out;
  end
endmodule // hf_oscillator_system_clock_control_test
